/* File: common/lic_pkg.sv */
package lic_pkg;
	localparam int NUM_IN = 20;
	localparam int NUM_CT = 14;
	localparam int NUM_FN = 11;
	localparam int SEL_W = 5;
	localparam int STRIDE = 8;
	localparam int PER_REG = 4;
	localparam int SEL_REGS = 5;
	localparam int FN_REGS = 3;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 250;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS * CLK_MHZ / 1000;
	localparam int PF_CYCLE_US = 16667;
	localparam int DEB_TICKS = (PF_CYCLE_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int DEB_CNT_W = 15;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [11:0] OFS_VIN = 12'h000;
	localparam logic [11:0] OFS_SEL0 = 12'h004;
	localparam logic [11:0] OFS_FN0 = 12'h018;
	localparam logic [11:0] OFS_LOGIC = 12'h024;
	localparam logic [11:0] OFS_CONTACT = 12'h028;
	localparam logic [11:0] OFS_BRK = 12'h02C;
	localparam logic [19:0] VIN_RST = 20'h00000;
	localparam logic [4:0] FN_RST = 5'h00;
	localparam int BRK_CLOSED_BIT = 0;
	localparam int BRK_OPEN_BIT = 1;
	localparam int BRK_UNKNOWN_BIT = 2;
	localparam int BRK_CONN_BIT = 3;
	localparam int LOCAL_BIT = 4;
	localparam int GROUP_LSB = 5;
	// Function slots, one 5-bit input number each (0 = disabled)
	localparam int FN_AUX_NO = 0, FN_AUX_NC = 1, FN_RACKED = 2;
	localparam int FN_LOCAL = 3, FN_RESET = 4, FN_COLD = 5;
	localparam int FN_GRP2 = 6, FN_GRP3 = 7, FN_GRP4 = 8;
	localparam int FN_ROPEN = 9, FN_RCLOSE = 10;

	typedef enum logic [4:0] {
		SEL_DISABLED, SEL_C_CLOSED, SEL_C_OPEN, SEL_V_ON, SEL_V_OFF,
		SEL_CL_AND_VON, SEL_CL_AND_VOFF, SEL_OP_AND_VON, SEL_OP_AND_VOFF,
		SEL_CL_OR_VON, SEL_CL_OR_VOFF, SEL_OP_OR_VON, SEL_OP_OR_VOFF,
		SEL_CL_XOR_VON, SEL_CL_XOR_VOFF, SEL_OP_XOR_VON, SEL_OP_XOR_VOFF
	} lic_sel_e;

	typedef struct packed {
		logic [NUM_IN-1:0][4:0] sel;
		logic [NUM_FN-1:0][4:0] fn;
		logic [NUM_IN-1:0] vin;
	} lic_cfg_s;

	typedef struct packed {
		logic [NUM_IN-1:0] lin;
		logic [NUM_CT-1:0] contact;
		logic [7:0] brk;
	} lic_stat_s;

	typedef struct packed {
		lic_cfg_s cfg;
		logic [31:0] rdata;
		logic err;
	} lic_regs_s;

	typedef struct packed {
		logic [NUM_CT-1:0] s1;
		logic [NUM_CT-1:0] s2;
		logic [NUM_CT-1:0] s3;
		logic [7:0] div;
		logic tick;
		logic [NUM_CT-1:0][DEB_CNT_W-1:0] cnt;
		logic [NUM_CT-1:0] stable;
	} lic_deb_s;

	typedef struct packed {
		logic [NUM_IN-1:0] lin;
		logic closed;
		logic open;
		logic unknown;
		logic conn;
		logic inhibit;
		logic local_m;
		logic clr_trip;
		logic clr_latch;
		logic clr_ar;
		logic cold;
		logic [1:0] group;
		logic trip;
		logic close;
	} lic_out_s;
endpackage : lic_pkg

/* File: hw/lic_debounce.sv */
`timescale 1ns/1ps
module lic_debounce #(
	parameter int DEB_TICKS = lic_pkg::DEB_TICKS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [lic_pkg::NUM_CT-1:0] pins,
	output logic [lic_pkg::NUM_CT-1:0] stable
);
	localparam logic [7:0] DIV_TOP = 8'(lic_pkg::TICK_CYCLES - 1);
	localparam logic [lic_pkg::DEB_CNT_W-1:0] CNT_TOP =
		lic_pkg::DEB_CNT_W'(DEB_TICKS - 1);
	lic_pkg::lic_deb_s st_reg;
	lic_pkg::lic_deb_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = pins;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// One microsecond enable from the divider
		st_next.tick = (st_reg.div == DIV_TOP);
		st_next.div = st_next.tick ? 8'h00 : st_reg.div + 8'h01;
		for (int i = 0; i < lic_pkg::NUM_CT; i++) begin
			// A bounce or a return to the old level restarts the dwell
			if (st_reg.s2[i] != st_reg.s3[i] ||
				st_reg.s3[i] == st_reg.stable[i]) begin
				st_next.cnt[i] = '0;
			end else if (st_reg.tick) begin
				if (st_reg.cnt[i] >= CNT_TOP) begin
					st_next.cnt[i] = '0;
					st_next.stable[i] = st_reg.s3[i];
				end else begin
					st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign stable = st_reg.stable;
endmodule : lic_debounce

/* File: hw/lic_apb_regs.sv */
`timescale 1ns/1ps
module lic_apb_regs (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pslverr,
	output lic_pkg::lic_cfg_s cfg,
	input wire lic_pkg::lic_stat_s stat
);
	lic_pkg::lic_regs_s st_reg;
	lic_pkg::lic_regs_s st_next;
	logic [31:0] mask;
	logic [31:0] word;

	function automatic logic [31:0] image(input lic_pkg::lic_cfg_s c,
		input lic_pkg::lic_stat_s s, input logic [11:0] a);
		logic [31:0] w;
		w = '0;
		for (int k = 0; k < lic_pkg::SEL_REGS; k++)
			for (int j = 0; j < lic_pkg::PER_REG; j++)
				if (a == lic_pkg::OFS_SEL0 + 12'(4 * k))
					w[lic_pkg::STRIDE*j +: 5] = c.sel[4*k+j];
		for (int k = 0; k < lic_pkg::FN_REGS; k++)
			for (int j = 0; j < lic_pkg::PER_REG; j++)
				if (a == lic_pkg::OFS_FN0 + 12'(4 * k) &&
					4 * k + j < lic_pkg::NUM_FN)
					w[lic_pkg::STRIDE*j +: 5] = c.fn[4*k+j];
		if (a == lic_pkg::OFS_VIN) w[19:0] = c.vin;
		if (a == lic_pkg::OFS_LOGIC) w[19:0] = s.lin;
		if (a == lic_pkg::OFS_CONTACT) w[13:0] = s.contact;
		if (a == lic_pkg::OFS_BRK) w[7:0] = s.brk;
		return w;
	endfunction : image

	function automatic logic mapped(input logic [11:0] a);
		return a[1:0] == 2'h0 && a <= lic_pkg::OFS_BRK;
	endfunction : mapped

	always_comb begin
		st_next = st_reg;
		mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		word = (image(st_reg.cfg, stat, paddr) & ~mask) | (pwdata & mask);
		if (psel && !penable) begin
			st_next.rdata = pwrite ? 32'h0000_0000 :
				image(st_reg.cfg, stat, paddr);
			st_next.err = !mapped(paddr);
		end
		if (psel && penable && pwrite && mapped(paddr)) begin
			// Virtual inputs are written only from the bus
			if (paddr == lic_pkg::OFS_VIN) st_next.cfg.vin = word[19:0];
			for (int k = 0; k < lic_pkg::SEL_REGS; k++)
				for (int j = 0; j < lic_pkg::PER_REG; j++)
					if (paddr == lic_pkg::OFS_SEL0 + 12'(4 * k))
						st_next.cfg.sel[4*k+j] = word[lic_pkg::STRIDE*j +: 5];
			for (int k = 0; k < lic_pkg::FN_REGS; k++)
				for (int j = 0; j < lic_pkg::PER_REG; j++)
					if (paddr == lic_pkg::OFS_FN0 + 12'(4 * k) &&
						4 * k + j < lic_pkg::NUM_FN)
						st_next.cfg.fn[4*k+j] = word[lic_pkg::STRIDE*j +: 5];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.cfg.vin <= lic_pkg::VIN_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pslverr = st_reg.err;
	assign cfg = st_reg.cfg;
endmodule : lic_apb_regs

/* File: hw/lic_logic_input_combiner.sv */
// Contract
// - Inputs 1-14 combine same-numbered contact and virtual by selector
// - Inputs 15-20 use only their virtual input, no contact
// - Selector 1-14 has seventeen codes including disabled, never asserted
// - AND codes assert only when both chosen polarities are true
// - OR codes assert when either chosen polarity is true
// - XOR codes assert when exactly one chosen polarity is true
// - Selector 15-20 offers disabled, virtual on, virtual off only
// - Contacts come from the pins; virtual inputs written by software
// - Asserted input drives every function it is assigned to
// - Both aux assigned: open-type closed means closed, other means open
// - Only normally-open aux: closed when shut, open otherwise
// - Only normally-closed aux: closed when that contact is open
// - No aux assigned: status unknown, breaker features inhibited
// - Racked-in input gives connection; disconnected shows neither state
// - Local mode while its input is asserted, remote otherwise
// - Reset clears last trip, latched relays, lockout when fitted
// - Cold load input starts cold load pickup blocking
// - Group inputs make group 2, 3 or 4 active
// - Remote open/close drive trip/close relays only in remote mode
// - Contacts are debounced over one power frequency cycle
// - Virtual input is off at zero, on when nonzero
`timescale 1ns/1ps
module lic_logic_input_combiner #(
	parameter int DEB_TICKS = lic_pkg::DEB_TICKS,
	parameter bit HAS_AUTORECLOSE = 1'b1
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [lic_pkg::NUM_CT-1:0] CONTACT_PIN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [lic_pkg::NUM_IN-1:0] LOGIC_IN,
	output logic BRK_CLOSED,
	output logic BRK_OPEN,
	output logic BRK_UNKNOWN,
	output logic BRK_CONNECTED,
	output logic BRK_FEATURE_INHIBIT,
	output logic LOCAL_MODE,
	output logic CLR_LAST_TRIP,
	output logic CLR_LATCHED,
	output logic CLR_AR_LOCKOUT,
	output logic COLD_LOAD_INIT,
	output logic [1:0] ACTIVE_GROUP,
	output logic TRIP_RELAY,
	output logic CLOSE_RELAY
);
	// ************************************************************
	// Shared state and submodules
	// ************************************************************
	lic_pkg::lic_cfg_s cfg;
	lic_pkg::lic_stat_s stat;
	lic_pkg::lic_out_s st_reg;
	lic_pkg::lic_out_s st_next;
	logic [lic_pkg::NUM_CT-1:0] deb;
	logic no_a;
	logic nc_a;
	logic rk_a;
	logic no_v;
	logic nc_v;
	logic conn;

	lic_debounce #(
		.DEB_TICKS(DEB_TICKS)
	) u_deb (
		.clk(CLK),
		.rstn(RSTN),
		.pins(CONTACT_PIN),
		.stable(deb)
	);

	lic_apb_regs u_regs (
		.clk(CLK),
		.rstn(RSTN),
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.pwdata(PWDATA),
		.pstrb(PSTRB),
		.prdata(PRDATA),
		.pslverr(PSLVERR),
		.cfg(cfg),
		.stat(stat)
	);

	// Zero wait states: every access ends in one access cycle
	assign PREADY = 1'b1;

	// ************************************************************
	// Decoding functions
	// ************************************************************
	// c is contact closed, v is virtual on
	function automatic logic comb_ct(input logic [4:0] code,
		input logic c, input logic v);
		logic r;
		r = 1'b0;
		unique case (lic_pkg::lic_sel_e'(code))
			lic_pkg::SEL_DISABLED: r = 1'b0;
			lic_pkg::SEL_C_CLOSED: r = c;
			lic_pkg::SEL_C_OPEN: r = !c;
			lic_pkg::SEL_V_ON: r = v;
			lic_pkg::SEL_V_OFF: r = !v;
			lic_pkg::SEL_CL_AND_VON: r = c && v;
			lic_pkg::SEL_CL_AND_VOFF: r = c && !v;
			lic_pkg::SEL_OP_AND_VON: r = !c && v;
			lic_pkg::SEL_OP_AND_VOFF: r = !c && !v;
			lic_pkg::SEL_CL_OR_VON: r = c || v;
			lic_pkg::SEL_CL_OR_VOFF: r = c || !v;
			lic_pkg::SEL_OP_OR_VON: r = !c || v;
			lic_pkg::SEL_OP_OR_VOFF: r = !c || !v;
			lic_pkg::SEL_CL_XOR_VON: r = c ^ v;
			lic_pkg::SEL_CL_XOR_VOFF: r = c ^ !v;
			lic_pkg::SEL_OP_XOR_VON: r = !c ^ v;
			lic_pkg::SEL_OP_XOR_VOFF: r = !c ^ !v;
			// Codes above the table never assert
			default: r = 1'b0;
		endcase
		return r;
	endfunction : comb_ct

	// Virtual-only inputs; contact codes behave as disabled
	function automatic logic comb_vi(input logic [4:0] code,
		input logic v);
		logic r;
		r = 1'b0;
		unique case (lic_pkg::lic_sel_e'(code))
			lic_pkg::SEL_V_ON: r = v;
			lic_pkg::SEL_V_OFF: r = !v;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : comb_vi

	// Input number 1..20 is valid; breaker slots accept only 1..14
	function automatic logic assigned(input logic [4:0] n,
		input logic ct_only);
		logic r;
		r = n != 5'h00 && n <= 5'(lic_pkg::NUM_IN);
		if (ct_only && n > 5'(lic_pkg::NUM_CT)) r = 1'b0;
		return r;
	endfunction : assigned

	function automatic logic pick(input logic [19:0] li,
		input logic [4:0] n, input logic ct_only);
		logic r;
		r = 1'b0;
		if (assigned(n, ct_only)) r = li[n - 5'h01];
		return r;
	endfunction : pick

	// ************************************************************
	// Combination and function logic
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		// Every output is decoded from the current inputs and registered, so it appears one cycle later
		for (int i = 0; i < lic_pkg::NUM_IN; i++) begin
			if (i < lic_pkg::NUM_CT) begin
				st_next.lin[i] = comb_ct(cfg.sel[i], deb[i], cfg.vin[i]);
			end else begin
				st_next.lin[i] = comb_vi(cfg.sel[i], cfg.vin[i]);
			end
		end
		// Misassigned breaker slots count as unassigned
		no_a = assigned(cfg.fn[lic_pkg::FN_AUX_NO], 1'b1);
		nc_a = assigned(cfg.fn[lic_pkg::FN_AUX_NC], 1'b1);
		rk_a = assigned(cfg.fn[lic_pkg::FN_RACKED], 1'b1);
		no_v = pick(st_next.lin, cfg.fn[lic_pkg::FN_AUX_NO], 1'b1);
		nc_v = pick(st_next.lin, cfg.fn[lic_pkg::FN_AUX_NC], 1'b1);
		// No racked-in input assigned: assume connected
		conn = !rk_a || pick(st_next.lin, cfg.fn[lic_pkg::FN_RACKED],
			1'b1);
		st_next.conn = conn;
		st_next.unknown = !no_a && !nc_a;
		st_next.inhibit = !no_a && !nc_a;
		if (no_a && nc_a) begin
			st_next.closed = no_v;
			st_next.open = nc_v;
		end else if (no_a) begin
			st_next.closed = no_v;
			st_next.open = !no_v;
		end else if (nc_a) begin
			st_next.closed = !nc_v;
			st_next.open = nc_v;
		end else begin
			st_next.closed = 1'b0;
			st_next.open = 1'b0;
		end
		if (!conn) begin
			st_next.closed = 1'b0;
			st_next.open = 1'b0;
		end
		st_next.local_m = pick(st_next.lin,
			cfg.fn[lic_pkg::FN_LOCAL], 1'b0);
		st_next.clr_trip = pick(st_next.lin,
			cfg.fn[lic_pkg::FN_RESET], 1'b0);
		st_next.clr_latch = st_next.clr_trip;
		st_next.clr_ar = st_next.clr_trip && HAS_AUTORECLOSE;
		st_next.cold = pick(st_next.lin,
			cfg.fn[lic_pkg::FN_COLD], 1'b0);
		// Highest group wins when several are asserted
		if (pick(st_next.lin, cfg.fn[lic_pkg::FN_GRP4], 1'b0)) begin
			st_next.group = 2'h3;
		end else if (pick(st_next.lin, cfg.fn[lic_pkg::FN_GRP3],
			1'b0)) begin
			st_next.group = 2'h2;
		end else if (pick(st_next.lin, cfg.fn[lic_pkg::FN_GRP2],
			1'b0)) begin
			st_next.group = 2'h1;
		end else begin
			st_next.group = 2'h0;
		end
		st_next.trip = !st_next.local_m && pick(st_next.lin,
			cfg.fn[lic_pkg::FN_ROPEN], 1'b0);
		st_next.close = !st_next.local_m && pick(st_next.lin,
			cfg.fn[lic_pkg::FN_RCLOSE], 1'b0);
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// Outputs and readback
	// ************************************************************
	assign LOGIC_IN = st_reg.lin;
	assign BRK_CLOSED = st_reg.closed;
	assign BRK_OPEN = st_reg.open;
	assign BRK_UNKNOWN = st_reg.unknown;
	assign BRK_CONNECTED = st_reg.conn;
	assign BRK_FEATURE_INHIBIT = st_reg.inhibit;
	assign LOCAL_MODE = st_reg.local_m;
	assign CLR_LAST_TRIP = st_reg.clr_trip;
	assign CLR_LATCHED = st_reg.clr_latch;
	assign CLR_AR_LOCKOUT = st_reg.clr_ar;
	assign COLD_LOAD_INIT = st_reg.cold;
	assign ACTIVE_GROUP = st_reg.group;
	assign TRIP_RELAY = st_reg.trip;
	assign CLOSE_RELAY = st_reg.close;

	always_comb begin
		stat.lin = st_reg.lin;
		stat.contact = deb;
		stat.brk = '0;
		stat.brk[lic_pkg::BRK_CLOSED_BIT] = st_reg.closed;
		stat.brk[lic_pkg::BRK_OPEN_BIT] = st_reg.open;
		stat.brk[lic_pkg::BRK_UNKNOWN_BIT] = st_reg.unknown;
		stat.brk[lic_pkg::BRK_CONN_BIT] = st_reg.conn;
		stat.brk[lic_pkg::LOCAL_BIT] = st_reg.local_m;
		stat.brk[lic_pkg::GROUP_LSB +: 2] = st_reg.group;
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_sel0(logic [4:0] code);
		cfg.sel[0] == code;
	endsequence

	sequence s_only_no;
		cfg.fn[lic_pkg::FN_AUX_NO] == 5'h01 &&
			cfg.fn[lic_pkg::FN_AUX_NC] == 5'h00;
	endsequence

	property p_disabled;
		@(posedge CLK) disable iff (!RSTN)
		s_sel0(lic_pkg::SEL_DISABLED) |=> !LOGIC_IN[0];
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled input asserted");

	property p_and;
		@(posedge CLK) disable iff (!RSTN)
		s_sel0(lic_pkg::SEL_CL_AND_VON) |=>
			LOGIC_IN[0] == ($past(deb[0]) && $past(cfg.vin[0]));
	endproperty
	a_and: assert property (p_and)
		else $error("and combination wrong");

	property p_or;
		@(posedge CLK) disable iff (!RSTN)
		s_sel0(lic_pkg::SEL_OP_OR_VOFF) |=>
			LOGIC_IN[0] == (!$past(deb[0]) || !$past(cfg.vin[0]));
	endproperty
	a_or: assert property (p_or)
		else $error("or combination wrong");

	property p_xor;
		@(posedge CLK) disable iff (!RSTN)
		s_sel0(lic_pkg::SEL_CL_XOR_VON) |=>
			LOGIC_IN[0] == ($past(deb[0]) ^ $past(cfg.vin[0]));
	endproperty
	a_xor: assert property (p_xor)
		else $error("xor combination wrong");

	property p_virt_only;
		@(posedge CLK) disable iff (!RSTN)
		cfg.sel[19] != 5'(lic_pkg::SEL_V_ON) &&
			cfg.sel[19] != 5'(lic_pkg::SEL_V_OFF) |=> !LOGIC_IN[19];
	endproperty
	a_virt_only: assert property (p_virt_only)
		else $error("virtual-only input asserted by other code");

	property p_only_no;
		@(posedge CLK) disable iff (!RSTN)
		s_only_no ##1 BRK_CONNECTED |-> BRK_CLOSED == LOGIC_IN[0] &&
			BRK_OPEN == !LOGIC_IN[0];
	endproperty
	a_only_no: assert property (p_only_no)
		else $error("single aux contact decode wrong");

	property p_unknown;
		@(posedge CLK) disable iff (!RSTN)
		BRK_UNKNOWN |-> !BRK_CLOSED && !BRK_OPEN && BRK_FEATURE_INHIBIT;
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("unknown breaker shows a position");

	property p_disc;
		@(posedge CLK) disable iff (!RSTN)
		!BRK_CONNECTED |-> !BRK_CLOSED && !BRK_OPEN;
	endproperty
	a_disc: assert property (p_disc)
		else $error("disconnected breaker shows a position");

	property p_remote;
		@(posedge CLK) disable iff (!RSTN)
		LOCAL_MODE |-> !TRIP_RELAY && !CLOSE_RELAY;
	endproperty
	a_remote: assert property (p_remote)
		else $error("remote command acted in local mode");

	property p_reset;
		@(posedge CLK) disable iff (!RSTN)
		CLR_LAST_TRIP |-> CLR_LATCHED &&
			CLR_AR_LOCKOUT == HAS_AUTORECLOSE;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset targets disagree");
endmodule : lic_logic_input_combiner

/* File: dv/lic_contact_model.sv */
`timescale 1ns/1ps
// Field contacts: follow the requested levels, or chatter
module lic_contact_model (
	input wire logic clk,
	input wire logic [13:0] want,
	input wire logic chatter,
	output logic [13:0] pins
);
	// Chatter flips every cycle, so no level ever dwells long enough
	always @(posedge clk) begin
		pins <= chatter ? ~pins : want;
	end
endmodule : lic_contact_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, chatter, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [13:0] want, pins;
	logic [lic_pkg::NUM_IN-1:0] logic_in;
	logic b_cl, b_op, b_unk, b_conn, b_inh, loc, c_trip, c_lat, c_ar, cold;
	logic trip, close;
	logic [1:0] grp;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;

	lic_contact_model u_cm (.clk(clk), .want(want), .chatter(chatter),
		.pins(pins));
	lic_logic_input_combiner #(.DEB_TICKS(3)) dut (.CLK(clk), .RSTN(rstn),
		.CONTACT_PIN(pins), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LOGIC_IN(logic_in),
		.BRK_CLOSED(b_cl), .BRK_OPEN(b_op), .BRK_UNKNOWN(b_unk),
		.BRK_CONNECTED(b_conn), .BRK_FEATURE_INHIBIT(b_inh),
		.LOCAL_MODE(loc), .CLR_LAST_TRIP(c_trip), .CLR_LATCHED(c_lat),
		.CLR_AR_LOCKOUT(c_ar), .COLD_LOAD_INIT(cold), .ACTIVE_GROUP(grp),
		.TRIP_RELAY(trip), .CLOSE_RELAY(close));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Whole run needs about 2400 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	// ************************************************************
	// Bus and checking helpers
	// ************************************************************
	task give_verdict();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	task chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Idle edge first, so back-to-back calls never redrive in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the bench timeout ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask : wr

	// Sample just after the edge, once registered outputs have landed
	task look(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : look

	function automatic logic f_sel(input int k, input logic c,
		input logic v);
		logic cp, vp;
		cp = ((k - 5) % 4 < 2) ? c : !c;
		vp = ((k - 5) % 2 == 0) ? v : !v;
		if (k < 5)
			return (k == 1) ? c : (k == 2) ? !c : (k == 3) ? v :
				(k == 4) ? !v : 1'b0;
		if (k < 9)
			return cp & vp;
		if (k < 13)
			return cp | vp;
		if (k < 17)
			return cp ^ vp;
		return 1'b0;
	endfunction : f_sel

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_regs();
		look(4);
		chk("unknown", b_unk, 32'h1);
		chk("inhibit", b_inh, 32'h1);
		apb(1'b0, 12'h030, 32'h0, 4'hF);
		chk("bad_err", er, 32'h1);
		chk("bad_data", rd, 32'h0);
		apb(1'b1, 12'h000, 32'hFFFFFFFF, 4'h1);
		apb(1'b0, 12'h000, 32'h0, 4'hF);
		chk("vin_strb", rd, 32'h000000FF);
		wr(12'h024, 32'hFFFFFFFF);
		chk("ro_err", er, 32'h0);
		apb(1'b0, 12'h024, 32'h0, 4'hF);
		chk("ro_logic", rd, 32'h0);
	endtask : t_regs

	task t_sel(input logic c);
		for (int v = 0; v < 2; v++) begin
			wr(12'h000, v);
			for (int k = 0; k < 18; k++) begin
				wr(12'h004, k);
				look(2);
				chk("sel", logic_in[0], f_sel(k, c, v[0]));
			end
		end
	endtask : t_sel

	task t_deb();
		int n;
		n = 0;
		for (int r = 0; r < 4; r++)
			wr(12'h004 + 12'(4 * r), 32'h01010101);
		wr(12'h000, 32'h0);
		want <= 14'h3FFF;
		chatter <= 1'b1;
		look(1200);
		chk("chatter", logic_in, 32'h0);
		@(posedge clk);
		chatter <= 1'b0;
		while (logic_in[13:0] !== 14'h3FFF && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("dwell", n >= 500, 32'h1);
		chk("contacts", logic_in, 32'h03FFF);
	endtask : t_deb

	task t_high();
		for (int v = 0; v < 2; v++) begin
			wr(12'h000, v << 14);
			for (int k = 0; k < 5; k++) begin
				wr(12'h010, k << 16);
				look(2);
				chk("hi", logic_in[14], (k == 3) ? v[0] :
					(k == 4) ? !v[0] : 1'b0);
			end
		end
	endtask : t_high

	task automatic t_brk();
		logic [31:0] fn[7] = '{32'h10030201, 32'h10030201, 32'h10030001,
			32'h10030200, 32'h10030000, 32'h10030201, 32'h1003000F};
		logic [31:0] sl[7] = '{32'h00030201, 32'h00030102, 32'h00030002,
			32'h00030202, 32'h00030201, 32'h00030201, 32'h00030201};
		logic [4:0] ex[7] = '{5'h12, 5'h0A, 5'h0A, 5'h12, 5'h07, 5'h00, 5'h07};
		for (int i = 0; i < 7; i++) begin
			wr(12'h018, fn[i]);
			wr(12'h004, sl[i]);
			wr(12'h000, (i == 5) ? 32'h0 : 32'h4);
			look(2);
			chk("brk", {b_cl, b_op, b_unk, b_conn, b_inh}, ex[i]);
		end
	endtask : t_brk

	task automatic t_ctl();
		logic [19:0] vi[7] = '{20'h04000, 20'h0C000, 20'h14000, 20'h24000,
			20'h44000, 20'h84000, 20'hE4000};
		logic [8:0] ex[7] = '{9'h0C0, 9'h100, 9'h0FC, 9'h0C1, 9'h0C2, 9'h0C3,
			9'h0C3};
		wr(12'h010, 32'h03030000);
		wr(12'h014, 32'h03030303);
		wr(12'h018, 32'h10000000);
		wr(12'h01C, 32'h13121111);
		wr(12'h020, 32'h000F0F14);
		for (int i = 0; i < 7; i++) begin
			wr(12'h000, {12'h0, vi[i]});
			look(2);
			chk("ctl", {loc, trip, close, c_trip, c_lat, c_ar, cold, grp},
				ex[i]);
			apb(1'b0, 12'h02C, 32'h0, 4'hF);
			chk("status", rd[6:4], {ex[i][1:0], ex[i][8]});
		end
	endtask : t_ctl

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		want = 14'h0000;
		chatter = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_sel(1'b0);
		t_deb();
		t_sel(1'b1);
		t_high();
		t_brk();
		t_ctl();
		give_verdict();
	end
endmodule : tb_top
